// [core/async_serial_pkg.sv]
/*
 * Constants shared by the asynchronous serial transmitter and receiver:
 * register indexes, bit positions, reset values, timing counts, states.
 * Assumes a bus slave that places register index N at byte address 4*N.
 */
package async_serial_pkg;

    // Register indexes; the byte address is four times the index.
    localparam logic [7:0] IX_INTERRUPT_CONTROL       = 8'h0b;
    localparam logic [7:0] IX_PERIPHERAL_FLAGS        = 8'h0c;
    localparam logic [7:0] IX_RECEIVE_STATUS_CONTROL  = 8'h18;
    localparam logic [7:0] IX_TRANSMIT_BUFFER         = 8'h19;
    localparam logic [7:0] IX_RECEIVE_FIFO            = 8'h1a;
    localparam logic [7:0] IX_PERIPHERAL_INT_ENABLES  = 8'h8c;
    localparam logic [7:0] IX_TRANSMIT_STATUS_CONTROL = 8'h98;
    localparam logic [7:0] IX_BAUD_DIVISOR            = 8'h99;

    // Fields of transmit_status_control.
    localparam int TSC_CLOCK_SOURCE = 7;
    localparam int TSC_NINE_SELECT  = 6;
    localparam int TSC_ENABLE       = 5;
    localparam int TSC_SYNC_SELECT  = 4;
    localparam int TSC_HIGH_SPEED   = 2;
    localparam int TSC_SHIFT_EMPTY  = 1;
    localparam int TSC_NINTH_BIT    = 0;

    // Fields of receive_status_control.
    localparam int RSC_PORT_ENABLE  = 7;
    localparam int RSC_NINE_SELECT  = 6;
    localparam int RSC_SINGLE_RX    = 5;
    localparam int RSC_CONTINUOUS   = 4;
    localparam int RSC_ADDR_DETECT  = 3;
    localparam int RSC_FRAMING_ERR  = 2;
    localparam int RSC_OVERRUN_ERR  = 1;
    localparam int RSC_NINTH_BIT    = 0;

    // Fields of peripheral_flags, peripheral_int_enables, interrupt_control.
    localparam int PF_RX_DATA       = 5;
    localparam int PF_TX_EMPTY      = 4;
    localparam int IC_GLOBAL_GATE   = 7;
    localparam int IC_PERIPH_GATE   = 6;

    // Reset values of the registers that read back.
    localparam logic [7:0] TSC_RESET = 8'h02;
    localparam logic [7:0] REG_RESET = 8'h00;

    // Timing: sixteen samples per bit, taken in the middle of a bit.
    localparam logic [3:0] SAMPLE_LAST = 4'hf;
    localparam logic [3:0] SAMPLE_MID  = 4'h7;
    // Low speed divides the baud tick by four more (x64 against x16).
    localparam logic [1:0] PRESCALE_LAST = 2'h3;
    localparam logic [1:0] FIFO_FULL     = 2'h2;
    localparam logic [3:0] FRAME_BITS_8  = 4'ha;
    localparam logic [3:0] FRAME_BITS_9  = 4'hb;
    localparam logic [3:0] DATA_LAST_8   = 4'h7;
    localparam logic [3:0] DATA_LAST_9   = 4'h8;

    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;

endpackage : async_serial_pkg

// [core/async_serial_tx_rx.sv]
/*
 * Asynchronous serial transmitter and receiver with its register file,
 * reached over an Avalon-MM slave with waitrequest.
 * Assumes rx_line is already synchronous to core_clk and that the pad
 * logic resolves tx_line from tx_line_oe.
 */
// The implementer's own choice: the Avalon-MM register port.
// Function
// - Shifter takes a new word only after the previous stop bit, at once.
// - Buffer-to-shifter move takes one cycle and sets the buffer-empty flag.
// - Buffer-empty flag ignores its enable; only a buffer load clears it.
// - Setting transmit enable sets the buffer-empty flag.
// - Read-only shifter-empty bit shows an idle shifter; no interrupt from it.
// - Sending needs enable, a loaded buffer and a baud shift clock.
// - Clearing transmit enable aborts, resets the transmitter, releases the pin.
// - Nine-bit mode sends the stored ninth bit; software sets it first.
// - Receive line sampled sixteen times per bit; data shifted per bit.
// - Receiver runs only while continuous receive is enabled.
// - After the stop bit a word enters the FIFO if room; flag then set.
// - Receive-data flag is read-only, cleared when the FIFO is empty.
// - Receive FIFO holds two words; two reads return both.
// - Stop bit with full FIFO sets overrun and drops the word.
// - Overrun blocks every further transfer into the FIFO.
// - Overrun clears whenever the receiver is disabled: continuous receive or port enable cleared, or sync set.
// - Stop bit sampled low sets the framing error of that word.
// - Framing error and ninth bit follow the oldest unread FIFO entry.
// - Interrupt needs flag, its enable, and both global gates.
// - Serial port enable with sync clear selects asynchronous mode.
// - Baud generator ticks at sixteen or sixty-four times the bit rate.
// - Frame: start bit, eight or nine data bits LSB first, stop bit.
module async_serial_tx_rx
    import async_serial_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    input  wire logic [9:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    input  wire logic        rx_line,
    output logic             tx_line,
    output logic             tx_line_oe,
    output logic             serial_irq
);

    typedef struct packed {
        logic [7:0]      int_ctl;
        logic [7:0]      int_en;
        logic            csrc;
        logic            tx9;
        logic            tx_enable;
        logic            sync;
        logic            high_speed_select;
        logic            tx_ninth_bit;
        logic            port_enable;
        logic            rx9;
        logic            sren;
        logic            rx_continuous_enable;
        logic            adden;
        logic [7:0]      divisor;
        logic [7:0]      txbuf;
        logic            buf_full;
        logic            tx_buffer_empty_flag;
        logic            busy;
        logic            run;
        logic [10:0]     transmit_shifter;
        logic [3:0]      tx_bits;
        logic [3:0]      tx_ph;
        logic [7:0]      bcnt;
        logic [1:0]      pre;
        rx_state_t       rx_st;
        logic [3:0]      rx_ph;
        logic [3:0]      rx_bits;
        logic [8:0]      receive_shifter;
        logic [1:0][9:0] fifo;
        logic            rd_ptr;
        logic [1:0]      count;
        logic            overrun_error;
        logic            irq;
        logic            txo;
        logic            txoe;
        logic            wreq;
        logic [7:0]      rdata;
    } state_t;

    state_t     q;
    state_t     n;
    logic       acc;
    logic [7:0] idx;
    logic       wr_tx;
    logic       bg_run;
    logic       os;
    logic       rx_en;
    logic       push;
    logic       pop;
    logic [9:0] head;

    // A request is taken at the edge where waitrequest is seen low.
    assign acc    = (read | write) & ~q.wreq;
    assign idx    = address[9:2];
    assign wr_tx  = acc & write & (idx == IX_TRANSMIT_BUFFER);
    assign head   = q.fifo[q.rd_ptr];
    // The generator is held in reset while neither direction is enabled.
    assign bg_run = q.tx_enable | q.rx_continuous_enable;
    assign os     = bg_run & (q.bcnt == 8'h00)
                    & (q.high_speed_select | (q.pre == PRESCALE_LAST));
    assign rx_en  = q.port_enable & q.rx_continuous_enable & ~q.sync;

    always_comb begin
        n    = q;
        push = 1'b0;
        pop  = 1'b0;

        // Bus slave: one wait cycle, then the answer.
        n.wreq = ~((read | write) & q.wreq);
        if (read & q.wreq) begin
            unique case (idx)
                IX_INTERRUPT_CONTROL:      n.rdata = q.int_ctl;
                IX_PERIPHERAL_FLAGS:       n.rdata = {2'b00, q.count != 2'b00,
                                                      q.tx_buffer_empty_flag, 4'h0};
                IX_RECEIVE_STATUS_CONTROL: n.rdata = {q.port_enable, q.rx9, q.sren,
                                                      q.rx_continuous_enable, q.adden, head[9],
                                                      q.overrun_error, head[8]};
                IX_TRANSMIT_BUFFER:        n.rdata = q.txbuf;
                IX_RECEIVE_FIFO:           n.rdata = head[7:0];
                IX_PERIPHERAL_INT_ENABLES: n.rdata = q.int_en;
                IX_TRANSMIT_STATUS_CONTROL: n.rdata = {q.csrc, q.tx9, q.tx_enable,
                                                      q.sync, 1'b0, q.high_speed_select,
                                                      ~q.busy, q.tx_ninth_bit};
                IX_BAUD_DIVISOR:           n.rdata = q.divisor;
                default:                   n.rdata = 8'h00;
            endcase
        end

        // Baud generator: a tick every divisor+1 clocks.
        if (!bg_run) begin
            n.bcnt = q.divisor;
            n.pre  = 2'b00;
        end else if (q.bcnt == 8'h00) begin
            n.bcnt = q.divisor;
            n.pre  = q.pre + 2'b01;
        end else begin
            n.bcnt = q.bcnt - 8'h01;
        end

        // Transmitter.
        if (!q.tx_enable) begin
            n.busy = 1'b0;
            n.run  = 1'b0;
        end else if (!q.busy) begin
            if (q.buf_full) begin
                // The whole frame is built at load, so the ninth bit is the one stored now.
                n.transmit_shifter      = {1'b1, q.tx9 ? q.tx_ninth_bit : 1'b1, q.txbuf, 1'b0};
                n.tx_bits  = q.tx9 ? FRAME_BITS_9 : FRAME_BITS_8;
                n.busy     = 1'b1;
                n.run      = 1'b0;
                n.tx_ph    = 4'h0;
                n.buf_full = 1'b0;
                n.tx_buffer_empty_flag     = 1'b1;
            end
        end else if (os) begin
            if (!q.run) begin
                n.run = 1'b1;
            end else begin
                n.tx_ph = q.tx_ph + 4'h1;
                if (q.tx_ph == SAMPLE_LAST) begin
                    n.transmit_shifter     = {1'b1, q.transmit_shifter[10:1]};
                    n.tx_bits = q.tx_bits - 4'h1;
                    if (q.tx_bits == 4'h1) begin
                        n.busy = 1'b0;
                        n.run  = 1'b0;
                    end
                end
            end
        end

        // Receiver: sample in the middle of each sixteenth-rate bit cell.
        if (!rx_en) begin
            n.rx_st = RX_IDLE;
            n.overrun_error  = 1'b0;
        end else if (os) begin
            unique case (q.rx_st)
                RX_IDLE: begin
                    if (!rx_line) begin
                        n.rx_st = RX_START;
                        n.rx_ph = 4'h0;
                    end
                end
                RX_START: begin
                    n.rx_ph = q.rx_ph + 4'h1;
                    if (q.rx_ph == SAMPLE_MID) begin
                        // A low glitch shorter than half a bit is no start.
                        n.rx_st   = rx_line ? RX_IDLE : RX_DATA;
                        n.rx_ph   = 4'h0;
                        n.rx_bits = 4'h0;
                    end
                end
                RX_DATA: begin
                    n.rx_ph = q.rx_ph + 4'h1;
                    if (q.rx_ph == SAMPLE_LAST) begin
                        n.receive_shifter[q.rx_bits] = rx_line;
                        n.rx_bits = q.rx_bits + 4'h1;
                        if (q.rx_bits == (q.rx9 ? DATA_LAST_9 : DATA_LAST_8)) begin
                            n.rx_st = RX_STOP;
                        end
                    end
                end
                RX_STOP: begin
                    n.rx_ph = q.rx_ph + 4'h1;
                    if (q.rx_ph == SAMPLE_LAST) begin
                        n.rx_st = RX_IDLE;
                        if (q.overrun_error) begin
                            push = 1'b0;
                        end else if (q.count == FIFO_FULL) begin
                            n.overrun_error = 1'b1;
                        end else begin
                            push = 1'b1;
                            // The slot behind the head; with one word stored it is the other one.
                            n.fifo[q.rd_ptr ^ q.count[0]] =
                                {~rx_line, q.rx9 & q.receive_shifter[8], q.receive_shifter[7:0]};
                        end
                    end
                end
            endcase
        end

        // Register writes and read side effects.
        if (acc & write) begin
            unique case (idx)
                IX_INTERRUPT_CONTROL:      n.int_ctl = writedata[7:0];
                IX_PERIPHERAL_INT_ENABLES: n.int_en = writedata[7:0];
                IX_BAUD_DIVISOR:           n.divisor = writedata[7:0];
                // A load in the same cycle as a move wins, so the flag shows the new word.
                IX_TRANSMIT_BUFFER: begin
                    n.txbuf    = writedata[7:0];
                    n.buf_full = 1'b1;
                    n.tx_buffer_empty_flag     = 1'b0;
                end
                IX_RECEIVE_STATUS_CONTROL: begin
                    n.port_enable  = writedata[RSC_PORT_ENABLE];
                    n.rx9   = writedata[RSC_NINE_SELECT];
                    n.sren  = writedata[RSC_SINGLE_RX];
                    n.rx_continuous_enable  = writedata[RSC_CONTINUOUS];
                    n.adden = writedata[RSC_ADDR_DETECT];
                end
                IX_TRANSMIT_STATUS_CONTROL: begin
                    n.csrc = writedata[TSC_CLOCK_SOURCE];
                    n.tx9  = writedata[TSC_NINE_SELECT];
                    n.tx_enable = writedata[TSC_ENABLE];
                    n.sync = writedata[TSC_SYNC_SELECT];
                    n.high_speed_select = writedata[TSC_HIGH_SPEED];
                    n.tx_ninth_bit = writedata[TSC_NINTH_BIT];
                    if (writedata[TSC_ENABLE] & ~q.tx_enable) begin
                        n.tx_buffer_empty_flag = 1'b1;
                    end
                end
                default: n.rdata = q.rdata;
            endcase
        end
        if (acc & read & (idx == IX_RECEIVE_FIFO) & (q.count != 2'b00)) begin
            pop      = 1'b1;
            n.rd_ptr = ~q.rd_ptr;
        end
        // A read and a stored word in one cycle leave the count unchanged.
        n.count = q.count + {1'b0, push} - {1'b0, pop};

        // Pin and interrupt outputs, all registered.
        n.txo  = (n.busy & n.run) ? n.transmit_shifter[0] : 1'b1;
        n.txoe = n.port_enable & n.tx_enable & ~n.sync;
        n.irq  = q.int_ctl[IC_GLOBAL_GATE] & q.int_ctl[IC_PERIPH_GATE]
                 & ((q.tx_buffer_empty_flag & q.int_en[PF_TX_EMPTY])
                 | ((q.count != 2'b00) & q.int_en[PF_RX_DATA]));
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            q       <= '0;
            q.wreq  <= 1'b1;
            q.txo   <= 1'b1;
            q.rx_st <= RX_IDLE;
        end else begin
            q <= n;
        end
    end

    assign readdata    = {24'h000000, q.rdata};
    assign waitrequest = q.wreq;
    assign tx_line     = q.txo;
    assign tx_line_oe  = q.txoe;
    assign serial_irq  = q.irq;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);

    sequence s_load;
        !q.busy && q.buf_full && q.tx_enable;
    endsequence

    sequence s_stop;
        rx_en && os && q.rx_st == RX_STOP && q.rx_ph == SAMPLE_LAST;
    endsequence

    load_at_once_a: assert property (s_load ##0 !wr_tx |=> q.busy && q.tx_buffer_empty_flag)
        else $error("shifter did not load from a full buffer");
    no_early_load_a: assert property ($fell(q.buf_full) |-> !$past(q.busy))
        else $error("buffer moved while the shifter was busy");
    flag_clear_a: assert property ($fell(q.tx_buffer_empty_flag) |-> $past(wr_tx))
        else $error("buffer-empty flag cleared without a buffer load");
    enable_flag_a: assert property ($rose(q.tx_enable) |-> q.tx_buffer_empty_flag)
        else $error("transmit enable did not set buffer-empty flag");
    idle_wait_a: assert property (q.busy && !q.run |-> q.txo)
        else $error("line left idle level before the first shift clock");
    abort_tx_a: assert property (!q.tx_enable |=> !q.busy && (q.tx_enable || !q.txoe))
        else $error("transmitter not reset after enable cleared");
    ninth_bit_a: assert property (s_load ##0 q.tx9 |=> q.transmit_shifter[9] == $past(q.tx_ninth_bit))
        else $error("ninth bit not loaded into the shifter");
    rx_off_a: assert property (!rx_en |=> q.rx_st == RX_IDLE && !q.overrun_error)
        else $error("receiver active while disabled");
    overrun_set_a: assert property (s_stop ##0 q.count == FIFO_FULL |=> q.overrun_error)
        else $error("overrun not flagged on full FIFO");
    overrun_hold_a: assert property (q.overrun_error |=> q.count <= $past(q.count))
        else $error("FIFO filled while overrun set");
    frame_err_a: assert property (
        s_stop ##0 !rx_line && !q.overrun_error && q.count != FIFO_FULL
        |=> q.fifo[$past(q.rd_ptr ^ q.count[0])][9])
        else $error("framing error not stored with the word");
    irq_gate_a: assert property (q.irq |-> $past(q.int_ctl[IC_GLOBAL_GATE])
        && $past(q.int_ctl[IC_PERIPH_GATE]))
        else $error("interrupt raised with a gate closed");

    // Further guards on the frame, the buffer, the sample rate, the pin and the status read.
    sequence s_tx_start;
        q.busy && !q.run && q.tx_enable && os;
    endsequence

    sequence s_rx_begin;
        rx_en && os && q.rx_st == RX_IDLE && !rx_line;
    endsequence

    start_bit_a: assert property (s_tx_start |=> q.run && !q.txo)
        else $error("start bit did not follow the first shift clock");
    line_idle_a: assert property (!q.busy |=> q.txo)
        else $error("transmit line not at idle level");
    buffer_free_a: assert property ($fell(q.buf_full) |-> q.busy && q.tx_buffer_empty_flag)
        else $error("buffer move did not set the buffer-empty flag");
    slow_rate_a: assert property (os && !q.high_speed_select |-> q.pre == PRESCALE_LAST)
        else $error("sample tick at the wrong rate");
    pin_owner_a: assert property (q.txoe |-> q.port_enable && q.tx_enable && !q.sync)
        else $error("transmit pin driven outside asynchronous mode");
    shift_empty_a: assert property (
        read && q.wreq && idx == IX_TRANSMIT_STATUS_CONTROL
        |=> q.rdata[TSC_SHIFT_EMPTY] == !$past(q.busy))
        else $error("shifter-empty bit does not follow the shifter");

    // Receive side.
    rx_start_a: assert property (s_rx_begin |=> q.rx_st == RX_START)
        else $error("falling receive line did not start a character");
    rx_hold_a: assert property (!os && rx_en |=> q.rx_st == $past(q.rx_st))
        else $error("receiver moved between sample ticks");
    push_flag_a: assert property (push |=> q.count != 2'b00)
        else $error("stored word did not raise the receive-data flag");
    rx_flag_a: assert property (
        read && q.wreq && idx == IX_PERIPHERAL_FLAGS
        |=> q.rdata[PF_RX_DATA] == ($past(q.count) != 2'b00))
        else $error("receive-data flag does not follow the FIFO");
    fifo_depth_a: assert property (q.count <= FIFO_FULL)
        else $error("receive FIFO holds more than two words");
    overrun_drop_a: assert property (s_stop ##0 q.count == FIFO_FULL |-> !push)
        else $error("word stored into a full FIFO");
    overrun_clear_a: assert property ($fell(q.overrun_error) |-> $past(!rx_en))
        else $error("overrun cleared without a receiver reset");

endmodule : async_serial_tx_rx

// [sim/serial_peer.sv]
/*
 * Remote serial peer: samples the device's transmit line at mid bit and
 * sends frames on the device's receive line.
 * Assumes line_in is already resolved, so a released pin reads high.
 */
module serial_peer (
    input  wire logic core_clk,
    input  wire logic line_in,
    output logic      line_out
);
    timeunit 1ns;
    timeprecision 1ps;

    int         bit_clks = 16;
    int         nbits    = 8;
    logic [8:0] rx_q[$];

    initial line_out = 1'b1;

    always begin : listen
        logic [8:0] v;
        @(negedge line_in);
        v = '0;
        repeat (bit_clks / 2) @(posedge core_clk);
        for (int i = 0; i < nbits; i++) begin
            repeat (bit_clks) @(posedge core_clk);
            v[i] = line_in;
        end
        repeat (bit_clks) @(posedge core_clk);
        rx_q.push_back(v);
    end

    // The idle gap after each frame keeps a low stop bit from posing as a start.
    task automatic send(input logic [8:0] w, input int n, input logic stop);
        line_out <= 1'b0;
        repeat (bit_clks) @(posedge core_clk);
        for (int i = 0; i < n; i++) begin
            line_out <= w[i];
            repeat (bit_clks) @(posedge core_clk);
        end
        line_out <= stop;
        repeat (bit_clks) @(posedge core_clk);
        line_out <= 1'b1;
        repeat (2 * bit_clks) @(posedge core_clk);
    endtask : send
endmodule : serial_peer

// [sim/async_serial_tx_rx_tb.sv]
/*
 * Self-checking bench for the serial block: registers over Avalon-MM,
 * frames exchanged with a remote peer model on both lines.
 * Assumes the transmit pin has a pull-up while released.
 */
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fail_count++; $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module async_serial_tx_rx_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import async_serial_pkg::*;

    logic        core_clk, sys_rst, read, write, waitrequest;
    logic        rx_line, tx_line, tx_line_oe, serial_irq, line_w, hs, nine, nb;
    logic [9:0]  address;
    logic [31:0] writedata, readdata;
    logic [7:0]  rd, w;
    logic [10:0] ea;
    logic [10:0] exp_q[$];
    logic [8:0]  ga;
    int          fail_count = 0;
    int          n_tests = 0;
    int          cyc = 0;
    int          seed = 47;

    assign line_w = tx_line_oe ? tx_line : 1'b1;

    async_serial_tx_rx dut_u (.core_clk(core_clk), .sys_rst(sys_rst), .address(address),
        .read(read), .write(write), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .rx_line(rx_line), .tx_line(tx_line),
        .tx_line_oe(tx_line_oe), .serial_irq(serial_irq));
    serial_peer peer_u (.core_clk(core_clk), .line_in(line_w), .line_out(rx_line));

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    task automatic tally_and_finish();
        if (fail_count == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            fail_count++;
            tally_and_finish();
        end
    end

    // One bus access; the idle edge at the end keeps back-to-back calls apart.
    task automatic bus(input logic wr, input logic [7:0] ix, input logic [7:0] d);
        address   <= {ix, 2'b00};
        writedata <= {24'h0, d};
        write     <= wr;
        read      <= !wr;
        @(posedge core_clk);
        while (waitrequest !== 1'b0) @(posedge core_clk);
        rd = readdata[7:0];
        write <= 1'b0;
        read  <= 1'b0;
        @(posedge core_clk);
    endtask : bus

    initial begin
        sys_rst   = 1'b1;
        read      = 1'b0;
        write     = 1'b0;
        address   = '0;
        writedata = '0;
        repeat (16) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        bus(0, IX_TRANSMIT_STATUS_CONTROL, 8'h00);
        `CHK("tsc reset", TSC_RESET, rd)
        bus(0, IX_PERIPHERAL_FLAGS, 8'h00);
        `CHK("flags reset", REG_RESET, rd)
        bus(1, 8'h01, 8'hff);
        bus(0, 8'h01, 8'h00);
        `CHK("unmapped", 8'h00, rd)
        bus(1, IX_RECEIVE_STATUS_CONTROL, 8'h90);
        for (int c = 0; c < 3; c++) begin
            hs   = (c != 1);
            nine = (c == 2);
            nb   = 1'($random(seed));
            peer_u.bit_clks = hs ? 16 : 64;
            peer_u.nbits    = nine ? 9 : 8;
            bus(1, IX_TRANSMIT_STATUS_CONTROL, {1'b0, nine, 1'b1, 2'b00, hs, 1'b0, nb});
            bus(0, IX_PERIPHERAL_FLAGS, 8'h00);
            `CHK("flag on enable", 1'b1, rd[PF_TX_EMPTY])
            for (int k = 0; k < 2; k++) begin
                w = 8'($random(seed));
                exp_q.push_back({2'b00, nine & nb, w});
                bus(1, IX_TRANSMIT_BUFFER, w);
            end
            bus(1, IX_PERIPHERAL_FLAGS, 8'h10);
            bus(0, IX_PERIPHERAL_FLAGS, 8'h00);
            `CHK("flag while queued", 1'b0, rd[PF_TX_EMPTY])
            bus(0, IX_TRANSMIT_STATUS_CONTROL, 8'h00);
            `CHK("shifter busy", 1'b0, rd[TSC_SHIFT_EMPTY])
            while (peer_u.rx_q.size() < 2) @(posedge core_clk);
            repeat (100) @(posedge core_clk);
            bus(1, IX_PERIPHERAL_FLAGS, 8'h00);
            bus(0, IX_PERIPHERAL_FLAGS, 8'h00);
            `CHK("flag after move", 1'b1, rd[PF_TX_EMPTY])
            bus(0, IX_TRANSMIT_STATUS_CONTROL, 8'h00);
            `CHK("shifter idle", 1'b1, rd[TSC_SHIFT_EMPTY])
            for (int k = 0; k < 2; k++) begin
                ea = exp_q.pop_front();
                ga = peer_u.rx_q.pop_front();
                `CHK("tx word", ea[8:0], ga)
            end
        end
        bus(1, IX_TRANSMIT_STATUS_CONTROL, 8'h24);
        bus(1, IX_TRANSMIT_BUFFER, 8'h00);
        repeat (40) @(posedge core_clk);
        bus(1, IX_TRANSMIT_STATUS_CONTROL, 8'h04);
        @(posedge core_clk);
        `CHK("pin released", 1'b0, tx_line_oe)
        bus(0, IX_TRANSMIT_STATUS_CONTROL, 8'h00);
        `CHK("tx reset", 1'b1, rd[TSC_SHIFT_EMPTY])
        repeat (300) @(posedge core_clk);
        peer_u.rx_q.delete();
        bus(1, IX_PERIPHERAL_INT_ENABLES, 8'h20);
        bus(1, IX_INTERRUPT_CONTROL, 8'hc0);
        for (int k = 0; k < 3; k++) begin
            w = 8'($random(seed));
            if (k < 2) exp_q.push_back({3'b000, w});
            peer_u.send({1'b0, w}, 8, 1'b1);
        end
        `CHK("rx irq", 1'b1, serial_irq)
        bus(1, IX_INTERRUPT_CONTROL, 8'h80);
        @(posedge core_clk);
        `CHK("gated irq", 1'b0, serial_irq)
        bus(0, IX_RECEIVE_STATUS_CONTROL, 8'h00);
        `CHK("overrun", 8'h92, rd)
        for (int k = 0; k < 2; k++) begin
            bus(0, IX_RECEIVE_FIFO, 8'h00);
            ea = exp_q.pop_front();
            `CHK("rx word", ea[7:0], rd)
        end
        bus(0, IX_PERIPHERAL_FLAGS, 8'h00);
        `CHK("rx flag clear", 1'b0, rd[PF_RX_DATA])
        peer_u.send(9'h05a, 8, 1'b1);
        bus(0, IX_PERIPHERAL_FLAGS, 8'h00);
        `CHK("overrun blocks", 1'b0, rd[PF_RX_DATA])
        bus(1, IX_RECEIVE_STATUS_CONTROL, 8'h80);
        peer_u.send(9'h0a5, 8, 1'b1);
        bus(0, IX_PERIPHERAL_FLAGS, 8'h00);
        `CHK("receiver off", 1'b0, rd[PF_RX_DATA])
        bus(1, IX_RECEIVE_STATUS_CONTROL, 8'hd0);
        bus(0, IX_RECEIVE_STATUS_CONTROL, 8'h00);
        `CHK("overrun cleared", 1'b0, rd[RSC_OVERRUN_ERR])
        for (int k = 0; k < 2; k++) begin
            nb = 1'($random(seed));
            w  = 8'($random(seed));
            exp_q.push_back({1'b0, k == 1, nb, w});
            peer_u.send({nb, w}, 9, k == 0);
        end
        for (int k = 0; k < 2; k++) begin
            ea = exp_q.pop_front();
            bus(0, IX_RECEIVE_STATUS_CONTROL, 8'h00);
            `CHK("rx status", ea[9:8], {rd[RSC_FRAMING_ERR], rd[RSC_NINTH_BIT]})
            bus(0, IX_RECEIVE_FIFO, 8'h00);
            `CHK("rx9 word", ea[7:0], rd)
        end
        tally_and_finish();
    end
endmodule : async_serial_tx_rx_tb
